//--- hw/sbwd_top.sv
/*
  Block write command decoder and runner with an APB register file.
  Assumes APB master on clk, a media sink with ready/done on clk,
  and an initiator data stream that carries protection info on last word.
*/
`timescale 1ns/1ps
module sbwd_top (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  input  wire logic                 blk_valid,
  input  wire sbwd_pkg::sbwd_beat_t blk_beat,
  input  wire sbwd_pkg::sbwd_pi_t   blk_pi,
  output logic                      blk_ready,
  output logic                      med_valid,
  output sbwd_pkg::sbwd_beat_t      med_beat,
  output sbwd_pkg::sbwd_pi_t        med_pi,
  output logic                      med_pi_valid,
  input  wire logic                 med_ready,
  input  wire logic                 med_done,
  output logic                      med_seek,
  output logic [63:0]               med_lba,
  output logic [3:0]                cache_prio,
  output logic [2:0]                duration_sel,
  output logic                      cmd_done
);
  import sbwd_pkg::*;

  logic [1:0]   rst_sync, widx, ridx;
  logic [31:0]  ctrl, next_ctrl, next_prdata;
  logic [127:0] cdb, next_cdb;
  logic         rst_n, next_pready, next_pslverr, acc, wr_fire, go, sts_clr, in_cdb;
  sbwd_cmd_t    parsed, cmd_q, next_cmd_q;
  sbwd_state_t  st, next_st;
  logic [63:0]  cur_lba, next_cur_lba, next_med_lba;
  logic [31:0]  remain, next_remain, blocks_done, next_blocks_done;
  sbwd_sense_t  sense, next_sense;
  logic         done_flag, next_done_flag, chk_flag, next_chk_flag;
  logic         next_blk_ready, next_med_valid, next_med_pi_valid, next_med_seek, next_cmd_done;
  sbwd_beat_t   next_med_beat;
  sbwd_pi_t     next_med_pi, gen_pi;
  logic [3:0]   next_cache_prio;
  logic [2:0]   next_duration_sel;
  logic         prot, type2, app_tag_owner_flag, beat_acc, last_acc, guard_bad, ref_bad;
  logic [15:0]  crc_next;

  // reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  sbwd_cdb_parser u_parser (
    .cdb (cdb),
    .cmd (parsed)
  );

  assign beat_acc = blk_valid && blk_ready;
  assign last_acc = beat_acc && blk_beat.last;

  sbwd_guard_crc u_crc (
    .clk      (clk),
    .rst_n    (rst_n),
    .en       (beat_acc || st == ST_DECODE),
    .clear    (last_acc || st == ST_DECODE),
    .data     (blk_beat.data),
    .crc_next (crc_next)
  );

  // apb slave, one wait state per access
  assign acc     = psel && penable && !pready;
  assign wr_fire = psel && penable && pready && pwrite;
  assign in_cdb  = paddr >= REG_CDB0 && paddr <= REG_CDB3 && paddr[1:0] == 2'h0;
  assign widx    = 2'((paddr - REG_CDB0) >> 2);
  assign ridx    = widx;
  assign go      = wr_fire && paddr == REG_GO && pwdata[0] && st == ST_IDLE;
  assign sts_clr = wr_fire && paddr == REG_STATUS && pwdata[1];

  always_comb begin
    next_ctrl    = ctrl;
    next_cdb     = cdb;
    next_pready  = acc;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (acc) begin
      next_prdata = 32'h0000_0000;
      if (in_cdb) begin
        next_prdata = cdb[32*ridx +: 32];
      end else begin
        case (paddr)
          REG_CTRL:   next_prdata = ctrl;
          REG_GO:     next_prdata = 32'h0000_0000;
          REG_STATUS: next_prdata = {29'h0, chk_flag, done_flag, st != ST_IDLE};
          REG_SENSE:  next_prdata = {12'h000, sense};
          REG_LBA_LO: next_prdata = cmd_q.lba[31:0];
          REG_LBA_HI: next_prdata = cmd_q.lba[63:32];
          REG_COUNT:  next_prdata = cmd_q.count;
          REG_OPTS:   next_prdata = {24'h0, cmd_q.dld, cmd_q.pcc, cmd_q.commit, cmd_q.hint};
          REG_BLKS:   next_prdata = blocks_done;
          default:    next_pslverr = 1'b1;
        endcase
      end
    end
    if (wr_fire && paddr == REG_CTRL) begin
      next_ctrl = pwdata;
    end
    // command block is frozen while a command runs
    if (wr_fire && in_cdb && st == ST_IDLE) begin
      next_cdb[32*widx +: 32] = pwdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= CTRL_RESET;
      cdb     <= 128'h0;
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      cdb     <= next_cdb;
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // format and generated protection information
  assign prot         = ctrl[CTRL_PROT_BIT];
  assign type2        = prot && ctrl[CTRL_PTYPE_LSB +: 3] == PTYPE2;
  assign app_tag_owner_flag          = ctrl[CTRL_ATO_BIT];
  assign gen_pi.guard = crc_next;
  assign gen_pi.reft  = type2 ? REF_TYPE2 : cur_lba[31:0];
  assign gen_pi.app   = app_tag_owner_flag ? APP_OWNED : APP_FREE;
  // host protection arrives with the last word of each block
  assign guard_bad = (cmd_q.pcc == 3'h1 || cmd_q.pcc == 3'h4) && blk_pi.guard != crc_next;
  assign ref_bad   = (cmd_q.pcc == 3'h1 || cmd_q.pcc == 3'h2) && blk_pi.reft != cur_lba[31:0];

  always_comb begin
    next_st           = st;
    next_cmd_q        = cmd_q;
    next_cur_lba      = cur_lba;
    next_remain       = remain;
    next_blocks_done  = blocks_done;
    next_sense        = sense;
    next_done_flag    = sts_clr ? 1'b0 : done_flag;
    next_chk_flag     = chk_flag;
    next_med_valid    = (med_valid && med_ready) ? 1'b0 : med_valid;
    next_med_beat     = med_beat;
    next_med_pi       = med_pi;
    next_med_pi_valid = med_pi_valid;
    next_med_seek     = 1'b0;
    next_med_lba      = med_lba;
    next_cache_prio   = cache_prio;
    next_duration_sel = duration_sel;
    next_cmd_done     = 1'b0;
    unique case (st)
      ST_IDLE: begin
        if (go) begin
          next_cmd_q       = parsed;
          next_blocks_done = 32'h0;
          next_st          = ST_DECODE;
        end
      end
      ST_DECODE: begin
        next_cache_prio   = cmd_q.hint ? PRIO_LOWEST : ctrl[CTRL_PRIO_LSB +: 4];
        next_duration_sel = cmd_q.dld;
        next_cur_lba      = cmd_q.lba;
        next_med_lba      = cmd_q.lba;
        next_remain       = cmd_q.count;
        next_sense        = '{SK_GOOD, ASC_NONE, 8'h00};
        if (!cmd_q.ok) begin
          next_sense = '{SK_ILLEGAL, ASC_INV_OPC, 8'h00};
          next_st    = ST_DONE;
        end else if (cmd_q.pcc > PCC_MAX) begin
          next_sense = '{SK_ILLEGAL, ASC_INV_FIELD, 8'h00};
          next_st    = ST_DONE;
        end else if (!prot && cmd_q.pcc != PCC_NONE) begin
          next_sense = '{SK_ILLEGAL, ASC_INV_FIELD, 8'h00};
          next_st    = ST_DONE;
        end else if (cmd_q.count == 32'h0) begin
          next_st = ST_SEEK;
        end else begin
          next_st = ST_XFER;
        end
      end
      ST_SEEK: begin
        next_med_seek = 1'b1;
        next_st       = ST_DONE;
      end
      ST_XFER: begin
        if (last_acc && (guard_bad || ref_bad)) begin
          // application tag never checked in these forms
          next_sense = '{SK_ABORTED, ASC_PI, guard_bad ? ASCQ_GUARD : ASCQ_REF};
          next_st    = ST_DONE;
        end else if (beat_acc) begin
          next_med_valid    = 1'b1;
          next_med_beat     = blk_beat;
          next_med_pi_valid = blk_beat.last && prot;
          next_med_pi       = cmd_q.pcc == PCC_NONE ? gen_pi : blk_pi;
          if (blk_beat.last) begin
            next_remain      = remain - 32'h1;
            next_cur_lba     = cur_lba + 64'h1;
            next_blocks_done = blocks_done + 32'h1;
            if (remain == 32'h1) begin
              next_st = cmd_q.commit ? ST_COMMIT : ST_DONE;
            end
          end
        end
      end
      ST_COMMIT: begin
        if (med_done) begin
          next_st = ST_DONE;
        end
      end
      ST_DONE: begin
        next_cmd_done  = 1'b1;
        next_done_flag = 1'b1;
        next_chk_flag  = sense.key != SK_GOOD;
        next_st        = ST_IDLE;
      end
    endcase
    // half rate intake keeps the output stage honest
    next_blk_ready = next_st == ST_XFER && !next_med_valid;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st           <= ST_IDLE;
      cmd_q        <= '0;
      cur_lba      <= 64'h0;
      remain       <= 32'h0;
      blocks_done  <= 32'h0;
      sense        <= '0;
      done_flag    <= 1'b0;
      chk_flag     <= 1'b0;
      blk_ready    <= 1'b0;
      med_valid    <= 1'b0;
      med_beat     <= '0;
      med_pi       <= '0;
      med_pi_valid <= 1'b0;
      med_seek     <= 1'b0;
      med_lba      <= 64'h0;
      cache_prio   <= 4'h0;
      duration_sel <= 3'h0;
      cmd_done     <= 1'b0;
    end else begin
      st           <= next_st;
      cmd_q        <= next_cmd_q;
      cur_lba      <= next_cur_lba;
      remain       <= next_remain;
      blocks_done  <= next_blocks_done;
      sense        <= next_sense;
      done_flag    <= next_done_flag;
      chk_flag     <= next_chk_flag;
      blk_ready    <= next_blk_ready;
      med_valid    <= next_med_valid;
      med_beat     <= next_med_beat;
      med_pi       <= next_med_pi;
      med_pi_valid <= next_med_pi_valid;
      med_seek     <= next_med_seek;
      med_lba      <= next_med_lba;
      cache_prio   <= next_cache_prio;
      duration_sel <= next_duration_sel;
      cmd_done     <= next_cmd_done;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_illegal_field;
    (st == ST_DONE && sense.key == SK_ILLEGAL && sense.asc == ASC_INV_FIELD) ##1 cmd_done;
  endsequence
  sequence s_seek_done;
    (st == ST_SEEK) ##1 (med_seek && st == ST_DONE) ##1 (cmd_done && sense.key == SK_GOOD);
  endsequence
  bad_code_a: assert property ((st == ST_DECODE && cmd_q.ok && !prot && cmd_q.pcc != PCC_NONE) |=> s_illegal_field)
    else $error("nonzero check code on unformatted drive not rejected");
  rsvd_code_a: assert property ((st == ST_DECODE && cmd_q.ok && cmd_q.pcc > PCC_MAX) |=> s_illegal_field)
    else $error("reserved check code not rejected");
  zero_seek_a: assert property ((st == ST_DECODE && cmd_q.ok && cmd_q.pcc == PCC_NONE && cmd_q.count == 32'h0)
                                |=> s_seek_done)
    else $error("zero count did not seek and finish good");
  low_prio_a: assert property ((st == ST_DECODE && cmd_q.hint) |=> cache_prio == PRIO_LOWEST)
    else $error("hint did not force lowest retention priority");
  commit_wait_a: assert property ((st == ST_COMMIT && !med_done) |=> !cmd_done ##1 !cmd_done)
    else $error("good status before media commit");
  gen_ref_a: assert property ((last_acc && prot && cmd_q.pcc == PCC_NONE)
                              |=> med_pi.reft == (type2 ? REF_TYPE2 : $past(cur_lba[31:0])) && med_pi_valid)
    else $error("generated reference tag wrong");
  gen_app_a: assert property ((last_acc && prot && cmd_q.pcc == PCC_NONE && app_tag_owner_flag) |=> med_pi.app == APP_OWNED)
    else $error("generated application tag not all ones");
  gen_guard_a: assert property ((last_acc && prot && cmd_q.pcc == PCC_NONE) |=> med_pi.guard == $past(crc_next))
    else $error("generated guard differs from block crc");
  guard_fail_a: assert property ((last_acc && cmd_q.pcc == 3'h4 && blk_pi.guard != crc_next)
                                 |=> st == ST_DONE && sense.key == SK_ABORTED && sense.ascq == ASCQ_GUARD)
    else $error("guard mismatch not aborted");
  skip_all_a: assert property ((last_acc && cmd_q.pcc == 3'h3) |=> sense.key != SK_ABORTED)
    else $error("code three must not check fields");
endmodule

//--- shared/sbwd_pkg.sv
/*
  Shared constants and types for the block write command decoder.
  Assumes a single clock domain and an APB register bus.
*/
package sbwd_pkg;
  localparam logic [7:0]  OPC_W10 = 8'h2A;
  localparam logic [7:0]  OPC_W12 = 8'hAA;
  localparam logic [7:0]  OPC_W16 = 8'h8A;
  localparam logic [2:0]  PCC_NONE = 3'h0;
  localparam logic [2:0]  PCC_MAX = 3'h4;
  localparam logic [2:0]  PTYPE2 = 3'h1;
  localparam logic [3:0]  SK_GOOD = 4'h0;
  localparam logic [3:0]  SK_ILLEGAL = 4'h5;
  localparam logic [3:0]  SK_ABORTED = 4'hB;
  localparam logic [7:0]  ASC_NONE = 8'h00;
  localparam logic [7:0]  ASC_INV_OPC = 8'h20;
  localparam logic [7:0]  ASC_INV_FIELD = 8'h24;
  localparam logic [7:0]  ASC_PI = 8'h10;
  localparam logic [7:0]  ASCQ_GUARD = 8'h01;
  localparam logic [7:0]  ASCQ_REF = 8'h03;
  localparam logic [31:0] REF_TYPE2 = 32'hFFFF_FFFF;
  localparam logic [15:0] APP_OWNED = 16'hFFFF;
  localparam logic [15:0] APP_FREE = 16'h0000;
  localparam logic [15:0] CRC_POLY = 16'h8BB7;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [3:0]  PRIO_LOWEST = 4'h0;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_CDB0 = 12'h004;
  localparam logic [11:0] REG_CDB3 = 12'h010;
  localparam logic [11:0] REG_GO = 12'h014;
  localparam logic [11:0] REG_STATUS = 12'h018;
  localparam logic [11:0] REG_SENSE = 12'h01C;
  localparam logic [11:0] REG_LBA_LO = 12'h020;
  localparam logic [11:0] REG_LBA_HI = 12'h024;
  localparam logic [11:0] REG_COUNT = 12'h028;
  localparam logic [11:0] REG_OPTS = 12'h02C;
  localparam logic [11:0] REG_BLKS = 12'h030;
  localparam int          CTRL_PROT_BIT = 0;
  localparam int          CTRL_PTYPE_LSB = 1;
  localparam int          CTRL_ATO_BIT = 4;
  localparam int          CTRL_PRIO_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef struct packed {
    logic        ok;
    logic [63:0] lba;
    logic [31:0] count;
    logic [2:0]  pcc;
    logic        hint;
    logic        commit;
    logic [2:0]  dld;
  } sbwd_cmd_t;

  typedef struct packed {
    logic [15:0] guard;
    logic [15:0] app;
    logic [31:0] reft;
  } sbwd_pi_t;

  typedef struct packed {
    logic [15:0] data;
    logic        last;
  } sbwd_beat_t;

  typedef struct packed {
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } sbwd_sense_t;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_DECODE = 6'h02,
    ST_SEEK   = 6'h04,
    ST_XFER   = 6'h08,
    ST_COMMIT = 6'h10,
    ST_DONE   = 6'h20
  } sbwd_state_t;
endpackage

//--- hw/sbwd_cdb_parser.sv
/*
  Command block field extraction for the 10, 12 and 16 byte writes.
  Assumes byte i of the command block sits at cdb[8*i+7:8*i].
*/
`timescale 1ns/1ps
module sbwd_cdb_parser (
  input  wire logic [127:0]      cdb,
  output sbwd_pkg::sbwd_cmd_t    cmd
);
  import sbwd_pkg::*;

  function automatic logic [63:0] msb_first(input logic [127:0] c, input int first, input int n);
    logic [63:0] v;
    v = 64'h0;
    for (int k = 0; k < n; k++) begin
      v = {v[55:0], c[8*(first+k) +: 8]};
    end
    return v;
  endfunction

  always_comb begin
    cmd        = '0;
    cmd.pcc    = cdb[15:13];
    cmd.hint   = cdb[12];
    cmd.commit = cdb[11];
    case (cdb[7:0])
      OPC_W10: begin
        cmd.ok    = 1'b1;
        cmd.lba   = msb_first(cdb, 2, 4);
        cmd.count = 32'(msb_first(cdb, 7, 2));
      end
      OPC_W12: begin
        cmd.ok    = 1'b1;
        cmd.lba   = msb_first(cdb, 2, 4);
        cmd.count = 32'(msb_first(cdb, 6, 4));
      end
      OPC_W16: begin
        cmd.ok    = 1'b1;
        cmd.lba   = msb_first(cdb, 2, 8);
        cmd.count = 32'(msb_first(cdb, 10, 4));
        cmd.dld   = {cdb[8], cdb[119:118]};
      end
      default: cmd.ok = 1'b0;
    endcase
  end
endmodule

//--- hw/sbwd_guard_crc.sv
/*
  Running guard CRC over 16-bit data words of one block.
  Assumes the caller pulses en per word and clear on the final word.
*/
`timescale 1ns/1ps
module sbwd_guard_crc (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        en,
  input  wire logic        clear,
  input  wire logic [15:0] data,
  output logic [15:0]      crc_next
);
  import sbwd_pkg::*;

  logic [15:0] crc;
  logic [15:0] next_crc;

  always_comb begin
    logic [15:0] c;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc_next = c;
    next_crc = en ? (clear ? CRC_INIT : c) : crc;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= CRC_INIT;
    end else begin
      crc <= next_crc;
    end
  end
endmodule

//--- testbench/sbwd_far_model.sv
/*
  Far side model: initiator word stream plus a media sink that stalls.
  Assumes the decoder's stream and media ports on one clock, resetn active low.
*/
`timescale 1ns/1ps
module sbwd_far_model
  import sbwd_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 resetn,
  output logic                      blk_valid,
  output sbwd_pkg::sbwd_beat_t      blk_beat,
  output sbwd_pkg::sbwd_pi_t        blk_pi,
  input  wire logic                 blk_ready,
  input  wire logic                 med_valid,
  input  wire sbwd_pkg::sbwd_beat_t med_beat,
  input  wire sbwd_pkg::sbwd_pi_t   med_pi,
  input  wire logic                 med_pi_valid,
  output logic                      med_ready,
  output logic                      med_done,
  output sbwd_pkg::sbwd_pi_t        last_pi,
  output logic [15:0]               last_word,
  output int                        n_done
);
  int dly;

  initial begin
    blk_valid = 1'b0;
    blk_beat  = '0;
    blk_pi    = '0;
  end

  // one block of n words, protection info rides with every block
  task automatic send(input int n, input logic [15:0] b, input sbwd_pi_t p);
    int k;
    for (int i = 0; i < n; i++) begin
      blk_valid <= 1'b1;
      blk_beat  <= '{data: b + 16'(i), last: (i == n - 1)};
      blk_pi    <= p;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (blk_ready !== 1'b1 && k < 50);
    end
    blk_valid <= 1'b0;
    blk_beat  <= '{data: ~blk_beat.data, last: 1'b0};
    blk_pi    <= ~p;
  endtask

  // media takes every other cycle, confirms commit 6 cycles after a block
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      med_ready <= 1'b0;
      med_done  <= 1'b0;
      dly       <= 0;
      n_done    <= 0;
      last_pi   <= '0;
      last_word <= 16'h0000;
    end else begin
      med_ready <= ~med_ready;
      med_done  <= (dly == 1);
      if (dly != 0) dly <= dly - 1;
      if (med_done) n_done <= n_done + 1;
      if (med_valid && med_ready) begin
        if (med_pi_valid) last_pi <= med_pi;
        if (med_beat.last) begin
          dly       <= 6;
          last_word <= med_beat.data;
        end
      end
    end
  end
endmodule

//--- testbench/sbwd_top_tb.sv
/*
  Self-checking bench for the block write decoder: APB tasks, command runs.
  Assumes the far side model and the decoder top on a 20 MHz clock.
*/
`timescale 1ns/1ps
module sbwd_top_tb;
  import sbwd_pkg::*;
  localparam int NW = 4;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, blk_valid, blk_ready, med_valid, med_pi_valid, med_ready;
  logic med_done, med_seek, cmd_done, seek_seen, rerr;
  sbwd_beat_t blk_beat, med_beat;
  sbwd_pi_t blk_pi, med_pi, last_pi, p;
  logic [63:0] med_lba;
  logic [3:0] cache_prio;
  logic [2:0] duration_sel;
  logic [7:0] cb [16];
  logic [15:0] g, last_word;
  logic [4:0] tv [7] = '{5'h06, 5'h05, 5'h0A, 5'h09, 5'h0F, 5'h12, 5'h11};
  int n_done, n0, n_mismatch = 0, total_checks = 0;

  always #25 clk = ~clk;

  sbwd_top dut_u (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .blk_valid, .blk_beat, .blk_pi, .blk_ready, .med_valid, .med_beat, .med_pi,
    .med_pi_valid, .med_ready, .med_done, .med_seek, .med_lba, .cache_prio, .duration_sel, .cmd_done);
  sbwd_far_model far_u (.clk, .resetn, .blk_valid, .blk_beat, .blk_pi, .blk_ready, .med_valid,
    .med_beat, .med_pi, .med_pi_valid, .med_ready, .med_done, .last_pi, .last_word, .n_done);

  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) n_mismatch++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ctrl(input logic on, input logic [2:0] ty, input logic own);
    apb(1'b1, REG_CTRL, {20'h00000, 4'h5, 3'h0, own, ty, on});
  endtask

  // most significant byte at the lowest byte number
  task automatic setf(input int pos, input int n, input logic [63:0] v);
    for (int i = 0; i < n; i++) cb[pos + i] = v[8 * (n - 1 - i) +: 8];
  endtask

  task automatic exec(input int nw, input sbwd_pi_t pi);
    int k;
    for (int i = 0; i < 4; i++) apb(1'b1, REG_CDB0 + 12'(4 * i), {cb[4*i+3], cb[4*i+2], cb[4*i+1], cb[4*i]});
    n0 = n_done;
    seek_seen = 1'b0;
    apb(1'b1, REG_GO, 32'h0000_0001);
    if (nw > 0) far_u.send(nw, 16'h0100, pi);
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (med_seek === 1'b1) seek_seen = 1'b1;
    end while (cmd_done !== 1'b1 && k < 200);
    // media commits counted up to the status pulse
    n0 = n_done - n0;
    chk("cmd_done", {63'h0, cmd_done}, 64'h1);
    apb(1'b0, REG_SENSE, 32'h0);
    repeat (12) @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl reset", rdat, CTRL_RESET);
    ctrl(1'b0, 3'h0, 1'b0);
    cb = '{default: 8'h00};
    cb[0] = OPC_W10;
    cb[1] = 8'h10;
    setf(2, 4, 64'h12345678);
    exec(0, '0);
    chk("sense", rdat, 64'h0);
    chk("seek", {63'h0, seek_seen}, 64'h1);
    chk("lba", med_lba, 64'h12345678);
    chk("prio", cache_prio, PRIO_LOWEST);
    apb(1'b0, REG_LBA_LO, 32'h0);
    chk("lba reg", rdat, 64'h12345678);
    $display("done: zero count 10");
    cb = '{default: 8'h00};
    cb[0] = OPC_W16;
    cb[1] = 8'h01;
    cb[14] = 8'h80;
    setf(2, 8, 64'h0123456789ABCDEF);
    exec(0, '0);
    chk("dsel", duration_sel, 3'b110);
    chk("lba16", med_lba, 64'h0123456789ABCDEF);
    chk("prio cfg", cache_prio, 4'h5);
    $display("done: zero count 16");
    for (int c = 1; c < 8; c++) begin
      ctrl(c > 4, 3'h0, 1'b0);
      cb = '{default: 8'h00};
      cb[0] = OPC_W10;
      cb[1] = {3'(c), 5'h00};
      setf(7, 2, 64'h1);
      exec(0, '0);
      chk("reject", rdat, {44'h0, SK_ILLEGAL, ASC_INV_FIELD, 8'h00});
    end
    cb = '{default: 8'h00};
    exec(0, '0);
    chk("bad opcode", rdat, {44'h0, SK_ILLEGAL, ASC_INV_OPC, 8'h00});
    $display("done: rejects");
    for (int t = 0; t < 2; t++) begin
      ctrl(1'b1, t ? PTYPE2 : 3'h0, t[0]);
      cb = '{default: 8'h00};
      cb[0] = OPC_W12;
      cb[1] = {4'h0, t[0], 3'h0};
      setf(2, 4, 64'hA1B2C3D4);
      setf(6, 4, 64'h1);
      exec(NW, 64'h5A5A_5A5A_5A5A_5A5A);
      g = CRC_INIT;
      for (int i = 0; i < NW; i++) g = crc(g, 16'h0100 + 16'(i));
      chk("sense", rdat, 64'h0);
      chk("guard", last_pi.guard, g);
      chk("ref", last_pi.reft, t ? REF_TYPE2 : 32'hA1B2C3D4);
      chk("app", last_pi.app, t ? APP_OWNED : APP_FREE);
      chk("commit", 64'(n0), 64'(t));
      chk("word", last_word, 16'h0100 + 16'(NW - 1));
    end
    $display("done: generated protection");
    ctrl(1'b1, 3'h0, 1'b0);
    for (int j = 0; j < 7; j++) begin
      cb = '{default: 8'h00};
      cb[0] = OPC_W10;
      cb[1] = {tv[j][4:2], 5'h00};
      setf(2, 4, 64'h00C0FFEE);
      setf(7, 2, 64'h1);
      p.guard = g ^ {15'h0, tv[j][1]};
      p.app = 16'h1234;
      p.reft = 32'h00C0FFEE ^ {31'h0, tv[j][0]};
      exec(NW, p);
      if ((tv[j][4:2] == 3'h1 || tv[j][4:2] == 3'h4) && tv[j][1])
        chk("pi fail", rdat, {44'h0, SK_ABORTED, ASC_PI, ASCQ_GUARD});
      else if ((tv[j][4:2] == 3'h1 || tv[j][4:2] == 3'h2) && tv[j][0])
        chk("pi fail", rdat, {44'h0, SK_ABORTED, ASC_PI, ASCQ_REF});
      else
        chk("pi pass", rdat, 64'h0);
    end
    $display("done: protection checks");
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped err", {63'h0, rerr}, 64'h1);
    chk("unmapped data", rdat, 64'h0);
    $display("done: unmapped");
    print_verdict();
  end

  function automatic logic [15:0] crc(input logic [15:0] c, input logic [15:0] d);
    logic fb;
    for (int j = 15; j >= 0; j--) begin
      fb = c[15] ^ d[j];
      c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
endmodule
